// file: hdl/expander_cfg.svh
// constants shared by both ends of the port-expander link
// assumes a 125 MHz system clock and a byte-wide register map
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

// fixed upper four bits of the slave address
`define DEV_ADDR_FIXED 4'h4

// register indices selected by the low three command bits
`define REG_IN0  3'h0
`define REG_IN1  3'h1
`define REG_OUT0 3'h2
`define REG_OUT1 3'h3
`define REG_INV0 3'h4
`define REG_INV1 3'h5
`define REG_DIR0 3'h6
`define REG_DIR1 3'h7

// reset values
`define RST_OUT 8'hff
`define RST_INV 8'h00
`define RST_DIR 8'hff
`define RST_PTR 8'h00

// controller register offsets
`define CSR_CTRL   8'h00
`define CSR_TXDATA 8'h04
`define CSR_STATUS 8'h08
`define CSR_RXDATA 8'h0c

// controller field positions
`define CTRL_ADDR_LSB 0
`define CTRL_RNW_BIT  7
`define CTRL_CMD_LSB  8
`define CTRL_TWO_BIT  16
`define CTRL_GO_BIT   31

// bus responses
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

// timing: serial clock is four quarter periods, rounded up for a least period
`define CLK_HZ 125000000
`define SCL_HZ 400000
`define QUARTER_CYCLES ((`CLK_HZ + 4 * `SCL_HZ - 1) / (4 * `SCL_HZ))

`endif

// file: hdl/expander_pkg.sv
// types shared by both ends of the port-expander link
// assumes nothing beyond a SystemVerilog compiler
package expander_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {
		DS_IDLE  = 3'b000,
		DS_ADDR  = 3'b001,
		DS_CMD   = 3'b010,
		DS_WRITE = 3'b011,
		DS_READ  = 3'b100,
		DS_SKIP  = 3'b101
	} dev_state_t;
	typedef enum logic [2:0] {
		MS_IDLE  = 3'b000,
		MS_NEXT  = 3'b001,
		MS_START = 3'b010,
		MS_BYTE  = 3'b011,
		MS_STOP  = 3'b100
	} ctrl_state_t;
	typedef enum logic [1:0] {
		IT_START = 2'b00,
		IT_TX    = 2'b01,
		IT_RX    = 2'b10,
		IT_STOP  = 2'b11
	} item_t;
endpackage

// file: hdl/i2c_link_if.sv
// two-wire link between the bus master and the expander
// assumes pull-ups: a line is high unless an enabled driver pulls it low
`timescale 1ns/1ps
interface i2c_link_if;
	logic sclOut;
	logic sclOe;
	logic sdaOutM;
	logic sdaOeM;
	logic sdaOutD;
	logic sdaOeD;
	logic scl;
	logic sda;
	// line resolution: scl from the master alone, sda wired-and of both ends
	assign scl = sclOe ? sclOut : 1'b1;
	assign sda = (sdaOeM ? sdaOutM : 1'b1) & (sdaOeD ? sdaOutD : 1'b1);
	modport ctrl (output sclOut, output sclOe, output sdaOutM, output sdaOeM, input scl, input sda);
	modport dev  (output sdaOutD, output sdaOeD, input scl, input sda);
endinterface

// file: hdl/expander_dev.sv
// sixteen-bit port expander: two-wire slave with four register pairs
// assumes scl, sda, straps and port pins are asynchronous to clk
//
// Operation
// - answers address 0100 plus three strap bits
// - address byte lsb one reads, zero writes
// - first byte after write address is pointer
// - low three pointer bits pick the register
// - master sends command bytes only when writing
// - reads begin at stored pointer until rewritten
// - input registers show pins, ignore writes
// - latches drive outputs only, read back latch
// - invert bit one flips returned input level
// - direction one is input, zero is output
// - write: address, command byte, then data bytes
// - write data alternates within pair, unlimited count
// - read: command write, restart, address with read
// - restart moves pointer to register in use
// - read bytes alternate between pair members
// - capture data on ack bit rising clock
// - master nacks the last byte it reads
// - stop ends transfer anytime, last ack valid
// - no general call; ack by pulling sda low
// - reset restores registers and link state
`timescale 1ns/1ps
`include "expander_cfg.svh"
module expander_dev (
	// link to the bus master
	i2c_link_if.dev             link,
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// address straps
	input  wire logic           addr_strap_bit0,
	input  wire logic           addr_strap_bit1,
	input  wire logic           addr_strap_bit2,
	// port half 0 pins
	input  wire expander_pkg::byte_t port_half0_pins_in,
	output logic [7:0]          port_half0_pins_out,
	output logic [7:0]          port_half0_pins_oe,
	// port half 1 pins
	input  wire expander_pkg::byte_t port_half1_pins_in,
	output logic [7:0]          port_half1_pins_out,
	output logic [7:0]          port_half1_pins_oe
);
	import expander_pkg::*;

	logic [20:0] syncA;
	logic [20:0] syncB;
	logic        sclD;
	logic        sdaD;
	logic        sclS;
	logic        sdaS;
	logic [2:0]  strapS;
	byte_t       pin0S;
	byte_t       pin1S;
	logic        startEv;
	logic        stopEv;
	logic        sclRise;
	logic        sclFall;
	logic        addrHit;
	logic        capture;

	dev_state_t  state;
	logic [3:0]  bitCnt;
	logic        inAck;
	byte_t       shiftReg;
	byte_t       txReg;
	logic        txOn;
	logic        ackDrv;
	logic [2:0]  curReg;
	logic        selected;

	byte_t       register_pointer_reg;
	byte_t       output_latch_half0_reg;
	byte_t       output_latch_half1_reg;
	byte_t       invert_select_half0_reg;
	byte_t       invert_select_half1_reg;
	byte_t       direction_half0_reg;
	byte_t       direction_half1_reg;

	// other member of a register pair
	function automatic logic [2:0] partner(input logic [2:0] idx);
		partner = idx ^ 3'h1;
	endfunction

	// value returned for a register index
	function automatic byte_t regRead(input logic [2:0] idx);
		case (idx)
			`REG_IN0:  regRead = pin0S ^ invert_select_half0_reg;
			`REG_IN1:  regRead = pin1S ^ invert_select_half1_reg;
			`REG_OUT0: regRead = output_latch_half0_reg;
			`REG_OUT1: regRead = output_latch_half1_reg;
			`REG_INV0: regRead = invert_select_half0_reg;
			`REG_INV1: regRead = invert_select_half1_reg;
			`REG_DIR0: regRead = direction_half0_reg;
			`REG_DIR1: regRead = direction_half1_reg;
			default:   regRead = 8'h00;
		endcase
	endfunction

	// two-flop synchronisers for link, straps and pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			syncA <= 21'h1fffff;
			syncB <= 21'h1fffff;
		end else begin
			syncA <= {link.scl, link.sda, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
				port_half1_pins_in, port_half0_pins_in};
			syncB <= syncA;
		end
	end

	// previous line levels for edge detection
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclD <= sclS;
			sdaD <= sdaS;
		end
	end

	// line events
	assign sclS    = syncB[20];
	assign sdaS    = syncB[19];
	assign strapS  = syncB[18:16];
	assign pin1S   = syncB[15:8];
	assign pin0S   = syncB[7:0];
	assign startEv = sclS && sclD && sdaD && !sdaS;
	assign stopEv  = sclS && sclD && !sdaD && sdaS;
	assign sclRise = sclS && !sclD;
	assign sclFall = !sclS && sclD;
	assign addrHit = (shiftReg[7:1] == {`DEV_ADDR_FIXED, strapS});
	assign capture = sclRise && inAck && (state == DS_WRITE);

	// serial slave state machine
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state                <= DS_IDLE;
			bitCnt               <= 4'h0;
			inAck                <= 1'b0;
			shiftReg             <= 8'h00;
			txReg                <= 8'h00;
			txOn                 <= 1'b0;
			ackDrv               <= 1'b0;
			curReg               <= 3'h0;
			selected             <= 1'b0;
			register_pointer_reg <= `RST_PTR;
		end else if (startEv) begin
			if (selected) begin
				register_pointer_reg <= {5'h00, curReg};
			end
			state  <= DS_ADDR;
			bitCnt <= 4'h0;
			inAck  <= 1'b0;
			txOn   <= 1'b0;
			ackDrv <= 1'b0;
		end else if (stopEv) begin
			state    <= DS_IDLE;
			selected <= 1'b0;
			txOn     <= 1'b0;
			ackDrv   <= 1'b0;
		end else if (sclRise) begin
			if (!inAck) begin
				shiftReg <= {shiftReg[6:0], sdaS};
				bitCnt   <= bitCnt + 4'h1;
			end else begin
				case (state)
					DS_ADDR: begin
						if (addrHit) begin
							selected <= 1'b1;
							if (shiftReg[0]) begin
								state  <= DS_READ;
								curReg <= register_pointer_reg[2:0];
							end else begin
								state <= DS_CMD;
							end
						end
					end
					DS_CMD: begin
						register_pointer_reg <= shiftReg;
						curReg               <= shiftReg[2:0];
						state                <= DS_WRITE;
					end
					DS_WRITE: curReg <= partner(curReg);
					DS_READ: begin
						if (sdaS) begin
							state <= DS_SKIP;
						end else begin
							curReg <= partner(curReg);
						end
					end
					default: ;
				endcase
			end
		end else if (sclFall) begin
			if (inAck) begin
				inAck  <= 1'b0;
				bitCnt <= 4'h0;
				ackDrv <= 1'b0;
				if (state == DS_READ) begin
					txReg <= regRead(curReg);
					txOn  <= 1'b1;
				end
			end else if (bitCnt == 4'h8) begin
				inAck  <= 1'b1;
				txOn   <= 1'b0;
				ackDrv <= (state == DS_ADDR && addrHit) || state == DS_CMD || state == DS_WRITE;
				if (state == DS_ADDR && !addrHit) begin
					state <= DS_SKIP;
				end
			end else if (txOn && bitCnt != 4'h0) begin
				txReg <= {txReg[6:0], 1'b0};
			end
		end
	end

	// register file written at the ack rising edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			output_latch_half0_reg  <= `RST_OUT;
			output_latch_half1_reg  <= `RST_OUT;
			invert_select_half0_reg <= `RST_INV;
			invert_select_half1_reg <= `RST_INV;
			direction_half0_reg     <= `RST_DIR;
			direction_half1_reg     <= `RST_DIR;
		end else if (capture) begin
			case (curReg)
				`REG_OUT0: output_latch_half0_reg  <= shiftReg;
				`REG_OUT1: output_latch_half1_reg  <= shiftReg;
				`REG_INV0: invert_select_half0_reg <= shiftReg;
				`REG_INV1: invert_select_half1_reg <= shiftReg;
				`REG_DIR0: direction_half0_reg     <= shiftReg;
				`REG_DIR1: direction_half1_reg     <= shiftReg;
				default:   ;
			endcase
		end
	end

	// pin drivers: latch value, enabled only where direction is output
	assign port_half0_pins_out = output_latch_half0_reg;
	assign port_half1_pins_out = output_latch_half1_reg;
	assign port_half0_pins_oe  = ~direction_half0_reg;
	assign port_half1_pins_oe  = ~direction_half1_reg;

	// open-drain data line: ack or a zero data bit pulls low
	assign link.sdaOutD = 1'b0;
	assign link.sdaOeD  = ackDrv || (txOn && !txReg[7]);
endmodule // expander_dev

// file: hdl/expander_ctrl.sv
// two-wire bus master driven from AXI4-Lite control registers
// assumes the expander never stretches the clock
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "expander_cfg.svh"
module expander_ctrl #(
	parameter int QUARTER = `QUARTER_CYCLES
) (
	// link to the expander
	i2c_link_if.ctrl            link,
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// write address and data
	input  wire logic [7:0]     awaddr,
	input  wire logic           awvalid,
	output logic                awready,
	input  wire logic [31:0]    wdata,
	input  wire logic [3:0]     wstrb,
	input  wire logic           wvalid,
	output logic                wready,
	// write response
	output logic [1:0]          bresp,
	output logic                bvalid,
	input  wire logic           bready,
	// read address and data
	input  wire logic [7:0]     araddr,
	input  wire logic           arvalid,
	output logic                arready,
	output logic [31:0]         rdata,
	output logic [1:0]          rresp,
	output logic                rvalid,
	input  wire logic           rready
);
	import expander_pkg::*;

	logic              awHeld;
	logic              wHeld;
	logic [7:0]        awAddrReg;
	logic [31:0]       wDataReg;
	logic [6:0]        devAddr;
	logic              rnw;
	byte_t             cmdByte;
	logic              two;
	logic [15:0]       txData;
	logic              goPulse;
	logic              busy;
	logic [1:0]        sdaSync;
	logic [7:0]        divCnt;
	logic              tick;
	ctrl_state_t       state;
	logic [2:0]        step;
	logic [1:0]        ph;
	logic [3:0]        bitIdx;
	byte_t             byteReg;
	item_t             kind;
	logic              nack;
	logic              lastRx;
	logic [15:0]       rxData;
	logic              sclDrv;
	logic              sdaDrv;

	// item for a sequence step
	function automatic item_t seqKind(input logic [2:0] s, input logic r, input logic t);
		case (s)
			3'd0:    seqKind = IT_START;
			3'd1:    seqKind = IT_TX;
			3'd2:    seqKind = IT_TX;
			3'd3:    seqKind = r ? IT_START : IT_TX;
			3'd4:    seqKind = (r || t) ? IT_TX : IT_STOP;
			3'd5:    seqKind = r ? IT_RX : IT_STOP;
			3'd6:    seqKind = (r && t) ? IT_RX : IT_STOP;
			default: seqKind = IT_STOP;
		endcase
	endfunction

	// byte sent at a sequence step
	function automatic byte_t seqByte(input logic [2:0] s);
		case (s)
			3'd1:    seqByte = {devAddr, 1'b0};
			3'd2:    seqByte = cmdByte;
			3'd3:    seqByte = txData[7:0];
			3'd4:    seqByte = rnw ? {devAddr, 1'b1} : txData[15:8];
			default: seqByte = 8'hff;
		endcase
	endfunction

	assign busy    = (state != MS_IDLE);
	assign awready = !awHeld && !bvalid;
	assign wready  = !wHeld && !bvalid;
	assign arready = !rvalid;
	assign tick    = (divCnt == 8'(QUARTER - 1));

	// write channels, control registers and response
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awHeld    <= 1'b0;
			wHeld     <= 1'b0;
			awAddrReg <= 8'h00;
			wDataReg  <= 32'h00000000;
			bvalid    <= 1'b0;
			bresp     <= `RESP_OKAY;
			devAddr   <= 7'h00;
			rnw       <= 1'b0;
			cmdByte   <= 8'h00;
			two       <= 1'b0;
			txData    <= 16'h0000;
			goPulse   <= 1'b0;
		end else begin
			goPulse <= 1'b0;
			if (awvalid && awready) begin
				awHeld    <= 1'b1;
				awAddrReg <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld    <= 1'b1;
				wDataReg <= wdata;
			end
			if (awHeld && wHeld) begin
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= `RESP_OKAY;
				case (awAddrReg)
					`CSR_CTRL: begin
						if (!busy) begin
							devAddr <= wDataReg[`CTRL_ADDR_LSB +: 7];
							rnw     <= wDataReg[`CTRL_RNW_BIT];
							cmdByte <= wDataReg[`CTRL_CMD_LSB +: 8];
							two     <= wDataReg[`CTRL_TWO_BIT];
							goPulse <= wDataReg[`CTRL_GO_BIT];
						end
					end
					`CSR_TXDATA: txData <= wDataReg[15:0];
					`CSR_STATUS: ;
					`CSR_RXDATA: ;
					default:     bresp <= `RESP_SLVERR;
				endcase
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= `RESP_OKAY;
			case (araddr)
				`CSR_CTRL:   rdata <= {15'h0000, two, cmdByte, rnw, devAddr};
				`CSR_TXDATA: rdata <= {16'h0000, txData};
				`CSR_STATUS: rdata <= {30'h00000000, nack, busy};
				`CSR_RXDATA: rdata <= {16'h0000, rxData};
				default: begin
					rdata <= 32'h00000000;
					rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// data line synchroniser and quarter-period divider
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sdaSync <= 2'b11;
			divCnt  <= 8'h00;
		end else begin
			sdaSync <= {sdaSync[0], link.sda};
			divCnt  <= tick ? 8'h00 : divCnt + 8'h01;
		end
	end

	// transfer sequencer: start, bytes, restart, stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state   <= MS_IDLE;
			step    <= 3'h0;
			ph      <= 2'h0;
			bitIdx  <= 4'h0;
			byteReg <= 8'h00;
			kind    <= IT_STOP;
			nack    <= 1'b0;
			lastRx  <= 1'b0;
			rxData  <= 16'h0000;
			sclDrv  <= 1'b0;
			sdaDrv  <= 1'b0;
		end else begin
			case (state)
				MS_IDLE: begin
					if (goPulse) begin
						step  <= 3'h0;
						nack  <= 1'b0;
						state <= MS_NEXT;
					end
				end
				MS_NEXT: begin
					kind    <= seqKind(step, rnw, two);
					byteReg <= seqByte(step);
					lastRx  <= (step == 3'd6) || !two;
					ph      <= 2'h0;
					bitIdx  <= 4'h0;
					case (seqKind(step, rnw, two))
						IT_START: state <= MS_START;
						IT_STOP:  state <= MS_STOP;
						default:  state <= MS_BYTE;
					endcase
				end
				MS_START: begin
					if (tick) begin
						ph <= ph + 2'h1;
						case (ph)
							2'h0: sdaDrv <= 1'b0;
							2'h1: sclDrv <= 1'b0;
							2'h2: sdaDrv <= 1'b1;
							default: begin
								sclDrv <= 1'b1;
								step   <= step + 3'h1;
								state  <= MS_NEXT;
							end
						endcase
					end
				end
				MS_BYTE: begin
					if (tick) begin
						ph <= ph + 2'h1;
						case (ph)
							2'h0: begin
								sclDrv <= 1'b1;
								if (bitIdx != 4'h8) begin
									sdaDrv <= (kind == IT_TX) && !byteReg[3'(7 - bitIdx)];
								end else begin
									sdaDrv <= (kind == IT_RX) && !lastRx;
								end
							end
							2'h1: sclDrv <= 1'b0;
							2'h2: begin
								if (bitIdx != 4'h8 && kind == IT_RX) begin
									byteReg <= {byteReg[6:0], sdaSync[1]};
								end
								if (bitIdx == 4'h8 && kind == IT_TX && sdaSync[1]) begin
									nack <= 1'b1;
								end
							end
							default: begin
								sclDrv <= 1'b1;
								bitIdx <= bitIdx + 4'h1;
								if (bitIdx == 4'h8) begin
									if (kind == IT_RX && step == 3'd5) begin
										rxData[7:0] <= byteReg;
									end
									if (kind == IT_RX && step == 3'd6) begin
										rxData[15:8] <= byteReg;
									end
									step  <= step + 3'h1;
									state <= nack ? MS_STOP : MS_NEXT;
									ph    <= 2'h0;
								end
							end
						endcase
					end
				end
				MS_STOP: begin
					if (tick) begin
						ph <= ph + 2'h1;
						case (ph)
							2'h0: begin
								sclDrv <= 1'b1;
								sdaDrv <= 1'b1;
							end
							2'h1: sclDrv <= 1'b0;
							2'h2: sdaDrv <= 1'b0;
							default: state <= MS_IDLE;
						endcase
					end
				end
				default: state <= MS_IDLE;
			endcase
		end
	end

	// open-drain drivers: enable pulls the line low
	assign link.sclOut  = 1'b0;
	assign link.sclOe   = sclDrv;
	assign link.sdaOutM = 1'b0;
	assign link.sdaOeM  = sdaDrv;
endmodule // expander_ctrl

// file: sim/expander_link_monitor.sv
// checker for the two-wire link between controller and expander
// assumes it is instantiated beside the link interface in the bench top
`timescale 1ns/1ps
module expander_link_monitor #(
	parameter int QUARTER = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link signals
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOutM,
	input wire logic sdaOeM,
	input wire logic sdaOutD,
	input wire logic sdaOeD,
	input wire logic scl,
	input wire logic sda
);
	logic       sclQ, sdaQ, inFrame, rwBit, addrAck;
	logic       sclRise, sclFall, startDet, stopDet;
	logic [3:0] bitCnt;
	logic [1:0] byteIdx;
	logic [7:0] shiftReg;
	// line edges and start/stop conditions
	assign sclRise = scl && !sclQ;
	assign sclFall = !scl && sclQ;
	assign startDet = scl && sclQ && sdaQ && !sda;
	assign stopDet = scl && sclQ && !sdaQ && sda;
	// frame flag and delayed lines
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			inFrame <= 1'b0;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			if (startDet)
				inFrame <= 1'b1;
			else if (stopDet)
				inFrame <= 1'b0;
		end
	end
	// bit and byte position, counted on clock falls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bitCnt <= 4'hf;
			byteIdx <= 2'h0;
		end else if (startDet) begin
			bitCnt <= 4'hf;
			byteIdx <= 2'h0;
		end else if (sclFall && inFrame) begin
			bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
			if (bitCnt == 4'h8 && byteIdx != 2'h3)
				byteIdx <= byteIdx + 2'h1;
		end
	end
	// sampled bits, direction and address acknowledge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shiftReg <= 8'h00;
			rwBit <= 1'b0;
			addrAck <= 1'b0;
		end else if (sclRise) begin
			shiftReg <= {shiftReg[6:0], sda};
			if (byteIdx == 2'h0 && bitCnt == 4'h7)
				rwBit <= sda;
			if (byteIdx == 2'h0 && bitCnt == 4'h8)
				addrAck <= sdaOeD;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_addr_bit;
		sclRise && inFrame && byteIdx == 2'h0 && bitCnt < 4'h8;
	endsequence
	sequence s_addr_ack;
		sclRise && inFrame && byteIdx == 2'h0 && bitCnt == 4'h8 && sdaOeD;
	endsequence
	sequence s_wr_bit;
		sclRise && inFrame && !rwBit && byteIdx != 2'h0 && bitCnt < 4'h8;
	endsequence
	sequence s_wr_ack;
		sclRise && inFrame && addrAck && !rwBit && byteIdx != 2'h0 && bitCnt == 4'h8;
	endsequence
	property p_addr_quiet; s_addr_bit |-> !sdaOeD; endproperty
	property p_ack_match; s_addr_ack |-> shiftReg[7:4] == 4'h4; endproperty
	property p_cmd_quiet; s_wr_bit |-> !sdaOeD; endproperty
	property p_write_ack; s_wr_ack |-> sdaOeD; endproperty
	property p_idle_quiet; !inFrame |-> !sdaOeD; endproperty
	property p_dev_stable; $changed(sdaOeD) |-> !scl; endproperty
	property p_reset_rel; $rose(rstn) |-> !sdaOeD && !sdaOeM && !sclOe; endproperty
	property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
	a_addr_quiet: assert property (p_addr_quiet)
		else $error("device drove sda inside an address byte");
	a_ack_match: assert property (p_ack_match)
		else $error("device acked a foreign address");
	a_cmd_quiet: assert property (p_cmd_quiet)
		else $error("device drove sda inside a write byte");
	a_write_ack: assert property (p_write_ack)
		else $error("device missed a write byte ack");
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("device drove sda outside a frame");
	a_dev_stable: assert property (p_dev_stable)
		else $error("device changed sda while scl high");
	a_reset_rel: assert property (p_reset_rel)
		else $error("link driven right after reset");
	a_scl_high: assert property (p_scl_high)
		else $error("scl high pulse too short");
endmodule // expander_link_monitor

// file: sim/test_i2c_sixteen_bit_port_expander_regs.sv
// bench joining controller and expander over the two-wire link
// assumes the hdl files and the link monitor are compiled first
`timescale 1ns/1ps
`include "expander_cfg.svh"
module test_i2c_sixteen_bit_port_expander_regs;
	import expander_pkg::*;
	localparam int Q = 10;
	typedef struct packed {logic [7:0] cmd; logic [15:0] tx, rx, oe;} row_t;
	logic        clk = 0, rstn = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, st, rx;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [2:0]  strap = 3'h5;
	logic [1:0]  rsp;
	byte_t       pin0 = 8'h5a, pin1 = 8'hc3;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] out0, oe0, out1, oe1;
	int          miscompares = 0, cmpCount = 0, cycles = 0;
	// write a pair, read it back, expected pin enables after
	row_t rows [8] = '{
		'{8'h02, 16'h3ca5, 16'h3ca5, 16'h0000}, '{8'h03, 16'h1196, 16'h1196, 16'h0000},
		'{8'h06, 16'h0f70, 16'h0f70, 16'hf08f}, '{8'h05, 16'h8001, 16'h8001, 16'hf08f},
		'{8'h00, 16'hffff, 16'hc2da, 16'hf08f}, '{8'h01, 16'h0000, 16'hdac2, 16'hf08f},
		'{8'h07, 16'hffff, 16'hffff, 16'h0000}, '{8'h04, 16'h0000, 16'h0000, 16'h0000}};
	i2c_link_if link();
	expander_ctrl #(.QUARTER(Q)) expander_ctrl_i (.link(link.ctrl), .clk(clk), .rstn(rstn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	expander_dev expander_dev_i (.link(link.dev), .clk(clk), .rstn(rstn),
		.addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
		.port_half0_pins_in(pin0), .port_half0_pins_out(out0), .port_half0_pins_oe(oe0),
		.port_half1_pins_in(pin1), .port_half1_pins_out(out1), .port_half1_pins_oe(oe1));
	expander_link_monitor #(.QUARTER(Q)) expander_link_monitor_i (.clk(clk), .rstn(rstn),
		.sclOut(link.sclOut), .sclOe(link.sclOe), .sdaOutM(link.sdaOutM), .sdaOeM(link.sdaOeM),
		.sdaOutD(link.sdaOutD), .sdaOeD(link.sdaOeD), .scl(link.scl), .sda(link.sda));
	// 125 MHz clock
	always #4 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			conclude();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmpCount++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one AXI write, both items offered together
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw, pb;
		ta = 0;
		tw = 0;
		pb = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (!(ta && tw)) begin
			@(negedge clk);
			pa = awvalid && awready;
			pw = wvalid && wready;
			@(posedge clk);
			if (pa) awvalid <= 0;
			if (pw) wvalid <= 0;
			ta |= pa;
			tw |= pw;
		end
		bready <= 1;
		while (!pb) begin
			@(negedge clk);
			pb = bvalid;
			rsp = bresp;
			@(posedge clk);
		end
		bready <= 0;
	endtask
	// one AXI read
	task axr(input logic [7:0] a, output logic [31:0] d);
		logic pa, pr;
		pa = 0;
		pr = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		while (!pa) begin
			@(negedge clk);
			pa = arready;
			@(posedge clk);
		end
		arvalid <= 0;
		rready <= 1;
		while (!pr) begin
			@(negedge clk);
			pr = rvalid;
			d = rdata;
			rsp = rresp;
			@(posedge clk);
		end
		rready <= 0;
	endtask
	// one link transfer, polled to completion
	task xfer(input logic [6:0] ad, input logic rd, input logic [7:0] cmd, input logic two,
		input logic [15:0] tx);
		axw(`CSR_TXDATA, {16'h0, tx});
		axw(`CSR_CTRL, {1'b1, 14'h0, two, cmd, rd, ad});
		st = 32'h1;
		while (st[0])
			axr(`CSR_STATUS, st);
		axr(`CSR_RXDATA, rx);
	endtask
	task conclude();
		$display("compares %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1;
		repeat (4) @(posedge clk);
		chk({14'h0, link.scl, link.sda}, 16'h3, "idle lines");
		foreach (rows[i]) begin
			xfer({4'h4, strap}, 0, rows[i].cmd, 1, rows[i].tx);
			chk({15'h0, st[1]}, 16'h0, "write nack");
			xfer({4'h4, strap}, 1, rows[i].cmd, 1, 16'h0);
			chk(rx[15:0], rows[i].rx, "read pair");
			chk({oe1, oe0}, rows[i].oe, "pin enables");
		end
		chk({out1, out0}, 16'h9611, "latch pins");
		$display("table test done");
		// every strap setting, with a near-miss address each time
		for (int s = 0; s < 8; s++) begin
			strap <= s[2:0];
			xfer({4'h4, s[2:0] ^ 3'h1}, 0, 8'h02, 0, 16'h0);
			chk({15'h0, st[1]}, 16'h1, "foreign ack");
			xfer({4'h4, s[2:0]}, 0, 8'h02, 0, {8'h0, s[7:0]});
			chk({15'h0, st[1]}, 16'h0, "own nack");
		end
		chk({8'h0, out0}, 16'h0007, "last write");
		xfer(7'h00, 0, 8'h02, 0, 16'h0);
		chk({15'h0, st[1]}, 16'h1, "general call");
		$display("address test done");
		axw(8'h10, 32'h0);
		chk({14'h0, rsp}, {14'h0, `RESP_SLVERR}, "bad write");
		axr(8'h14, st);
		chk({14'h0, rsp}, {14'h0, `RESP_SLVERR}, "bad read");
		$display("bus test done");
		// outputs enabled, then a second reset
		xfer({4'h4, strap}, 0, 8'h06, 1, 16'h0000);
		chk({oe1, oe0}, 16'hffff, "outputs on");
		@(posedge clk);
		rstn <= 0;
		repeat (6) @(posedge clk);
		rstn <= 1;
		repeat (4) @(posedge clk);
		chk({oe1, oe0}, 16'h0000, "reset enables");
		chk({out1, out0}, 16'hffff, "reset latches");
		for (int k = 1; k < 4; k++) begin
			xfer({4'h4, strap}, 1, 8'(2 * k), 1, 16'h0);
			chk(rx[15:0], (k == 2) ? 16'h0000 : 16'hffff, "reset value");
		end
		// pins changed, then a one-byte read nacked at once
		pin0 <= 8'h3c;
		xfer({4'h4, strap}, 1, 8'h00, 0, 16'h0);
		chk({8'h0, rx[7:0]}, 16'h003c, "single read");
		$display("reset test done");
		conclude();
	end
endmodule // test_i2c_sixteen_bit_port_expander_regs
